/* File: core/sppf_class_decode.sv */
// timer channel 3 setting decoder: output class and capture routing
`timescale 1ns/100ps
`default_nettype none
module sppf_class_decode
   import sppf_pkg::*;
(
   input  wire logic [3:0] timerMode,
   input  wire logic [3:0] dIoControl,
   input  wire logic [2:0] counterClear,
   output var  logic       outputClass,
   output var  logic       captureRoute
);
   always_comb begin
      outputClass = 1'b0;
      case (timerMode)
         MODE_NORMAL: begin
            // 0001-0011, 0101-0111 are compare outputs
            outputClass = ~dIoControl[3] && (dIoControl[1:0] != 2'h0);
         end
         MODE_PWM1: begin
            outputClass = 1'b0;
         end
         MODE_PWM2: begin
            // d register as period source gives no waveform
            outputClass = (dIoControl[1:0] != 2'h0) && (counterClear != CLR_BY_D);
         end
         default: begin
            outputClass = 1'b0;
         end
      endcase
   end
   assign captureRoute = (timerMode == MODE_NORMAL) && (dIoControl[3:2] == 2'h2);
endmodule // sppf_class_decode
`default_nettype wire

/* File: core/sppf_pin_select.sv */
// shared port pin function select with pulse next data registers
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - serial transmit enable forces the pin to carry serial transmit data
// - transmit off and timer output class: pin carries timer d compare output
// - otherwise direction and pulse enable pick port in, port out or pulse out
// - mode 0000 with d control 10xx routes pin to timer d capture
// - interrupt pin select feeds pin level to interrupt 11 input
// - mode 0000: d control 0001-0011, 0101-0111 is output class
// - mode 0010 always gives the non-output class
// - mode 0011 outputs only if d control not xx00 and clear not 110
// - pwm mode 2 gives no waveform on the period register pin
// - pwm mode 1 drives a and c pins only; mode 2 each pin
// - output trigger copies next data bits into pulse data bits
// - shared trigger maps all eight next bits at one address
// - split triggers map upper and lower halves to separate addresses
// - split layout unused half reads ones and ignores writes
// - next data bits are read-write and reset to zero
module sppf_pin_select
   import sppf_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic [sppf_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [sppf_pkg::DATA_W-1:0] regWrData,
   input  wire logic                    regWrite,
   input  wire logic                    regRead,
   output logic      [sppf_pkg::DATA_W-1:0] regRdData,
   input  wire logic                    triggerUpper,
   input  wire logic                    triggerLower,
   input  wire logic                    serialTxData,
   input  wire logic                    timerCompareD,
   input  wire logic                    timerPwmA,
   input  wire logic                    timerPwmB,
   input  wire logic                    timerPwmC,
   input  wire logic                    pinIn,
   output logic                         pinOut,
   output logic                         pinOe,
   output logic                         timerCaptureD,
   output logic                         extInt11,
   output logic                         pwmPinA,
   output logic                         pwmPinB,
   output logic                         pwmPinC,
   output logic      [sppf_pkg::DATA_W-1:0] pulseData
);
   import sppf_pkg::*;

   logic [7:0] nextData_q;
   logic [7:0] pulseData_q;
   logic [7:0] control_q;
   logic [7:0] timer_q;
   logic [2:0] clear_q;
   logic [7:0] regRdData_q;
   logic       pinSync1_q;
   logic       pinSync2_q;
   logic       pinOut_q;
   logic       pinOe_q;
   logic       capture_q;
   logic       extInt_q;
   logic       pwmA_q;
   logic       pwmB_q;
   logic       pwmC_q;
   logic       outputClass;
   logic       captureRoute;
   logic       sameTrig;
   sppf_func_t func;

   assign sameTrig = control_q[CTL_SAME_TRIG];

   sppf_class_decode u_decode (
      .timerMode    (timer_q[TMR_MODE_LSB +: 4]),
      .dIoControl   (timer_q[TMR_IOD_LSB +: 4]),
      .counterClear (clear_q),
      .outputClass  (outputClass),
      .captureRoute (captureRoute)
   );

   // pin is asynchronous to clk
   always_ff @(posedge clk) begin
      if (rst) begin
         pinSync1_q <= 1'b0;
         pinSync2_q <= 1'b0;
      end else begin
         pinSync1_q <= pinIn;
         pinSync2_q <= pinSync1_q;
      end
   end

   // next data registers, per-half write decode
   always_ff @(posedge clk) begin
      if (rst) begin
         nextData_q <= RST_ZERO;
      end else if (regWrite) begin
         if (sameTrig && regAddr == OFS_NEXT_COMB) begin
            nextData_q <= regWrData;
         end else if (!sameTrig && regAddr == OFS_NEXT_UPPER) begin
            nextData_q[7:4] <= regWrData[7:4];
         end else if (!sameTrig && regAddr == OFS_NEXT_LOWER) begin
            nextData_q[3:0] <= regWrData[3:0];
         end
      end
   end

   // trigger copies; shared trigger uses the lower trigger for both halves
   always_ff @(posedge clk) begin
      if (rst) begin
         pulseData_q <= RST_ZERO;
      end else begin
         if (sameTrig ? triggerLower : triggerUpper) begin
            pulseData_q[7:4] <= nextData_q[7:4];
         end
         if (triggerLower) begin
            pulseData_q[3:0] <= nextData_q[3:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         control_q <= RST_ZERO;
         timer_q   <= RST_ZERO;
         clear_q   <= 3'h0;
      end else if (regWrite) begin
         if (regAddr == OFS_CONTROL) begin
            control_q <= regWrData;
         end
         if (regAddr == OFS_TIMER) begin
            timer_q <= regWrData;
         end
         if (regAddr == OFS_STATUS) begin
            clear_q <= regWrData[CLR_LSB +: 3];
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         regRdData_q <= RST_ZERO;
      end else if (regRead) begin
         case (regAddr)
            OFS_NEXT_COMB:  regRdData_q <= sameTrig ? nextData_q : UNMAPPED_READ;
            OFS_NEXT_UPPER: regRdData_q <= sameTrig ? UNMAPPED_READ
                                                    : {nextData_q[7:4], RSV_ONES[3:0]};
            OFS_NEXT_LOWER: regRdData_q <= sameTrig ? UNMAPPED_READ
                                                    : {RSV_ONES[7:4], nextData_q[3:0]};
            OFS_CONTROL:    regRdData_q <= control_q;
            OFS_TIMER:      regRdData_q <= timer_q;
            OFS_STATUS:     regRdData_q <= {pinSync2_q, func, 1'b0, clear_q};
            OFS_PULSE_DATA: regRdData_q <= pulseData_q;
            default:        regRdData_q <= UNMAPPED_READ;
         endcase
      end else begin
         regRdData_q <= RST_ZERO;
      end
   end

   // priority: serial, then timer output, then port direction
   always_comb begin
      if (control_q[CTL_TX_EN]) begin
         func = PF_SERIAL_OUT;
      end else if (outputClass) begin
         func = PF_TIMER_OUT;
      end else if (!control_q[CTL_DIR]) begin
         func = PF_PORT_IN;
      end else if (!control_q[CTL_PO_EN]) begin
         func = PF_PORT_OUT;
      end else begin
         func = PF_PULSE_OUT;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pinOut_q <= 1'b0;
         pinOe_q  <= 1'b0;
      end else begin
         case (func)
            PF_SERIAL_OUT: begin
               pinOut_q <= serialTxData;
               pinOe_q  <= 1'b1;
            end
            PF_TIMER_OUT: begin
               pinOut_q <= timerCompareD;
               pinOe_q  <= 1'b1;
            end
            PF_PORT_OUT: begin
               pinOut_q <= control_q[CTL_PORT_DATA];
               pinOe_q  <= 1'b1;
            end
            PF_PULSE_OUT: begin
               pinOut_q <= pulseData_q[PIN_BIT];
               pinOe_q  <= 1'b1;
            end
            default: begin
               pinOut_q <= 1'b0;
               pinOe_q  <= 1'b0;
            end
         endcase
      end
   end

   // capture and interrupt see the pin whatever else is active
   always_ff @(posedge clk) begin
      if (rst) begin
         capture_q <= 1'b0;
         extInt_q  <= 1'b0;
      end else begin
         capture_q <= captureRoute & pinSync2_q;
         extInt_q  <= control_q[CTL_INT_SEL] & pinSync2_q;
      end
   end

   // a/b/c pins of channel 3: mode 1 pairs, mode 2 one per register
   always_ff @(posedge clk) begin
      if (rst) begin
         pwmA_q <= 1'b0;
         pwmB_q <= 1'b0;
         pwmC_q <= 1'b0;
      end else if (timer_q[TMR_MODE_LSB +: 4] == MODE_PWM1) begin
         pwmA_q <= timerPwmA;
         pwmB_q <= 1'b0;
         pwmC_q <= timerPwmC;
      end else begin
         pwmA_q <= timerPwmA;
         pwmB_q <= timerPwmB;
         pwmC_q <= timerPwmC;
      end
   end

   assign regRdData     = regRdData_q;
   assign pinOut        = pinOut_q;
   assign pinOe         = pinOe_q;
   assign timerCaptureD = capture_q;
   assign extInt11      = extInt_q;
   assign pwmPinA       = pwmA_q;
   assign pwmPinB       = pwmB_q;
   assign pwmPinC       = pwmC_q;
   assign pulseData     = pulseData_q;

   serial_wins_a : assert property (@(posedge clk) disable iff (rst)
      control_q[CTL_TX_EN] |=> pinOe && pinOut == $past(serialTxData))
      else $error("serial data not on pin");
   timer_out_a : assert property (@(posedge clk) disable iff (rst)
      !control_q[CTL_TX_EN] && outputClass |=> pinOe && pinOut == $past(timerCompareD))
      else $error("compare output not on pin");
   port_input_a : assert property (@(posedge clk) disable iff (rst)
      !control_q[CTL_TX_EN] && !outputClass && !control_q[CTL_DIR] |=> !pinOe)
      else $error("pin driven while input");
   capture_route_a : assert property (@(posedge clk) disable iff (rst)
      !captureRoute |=> !timerCaptureD)
      else $error("capture without routing");
   int_select_a : assert property (@(posedge clk) disable iff (rst)
      control_q[CTL_INT_SEL] |=> extInt11 == $past(pinSync2_q))
      else $error("interrupt input wrong");
   pwm1_class_a : assert property (@(posedge clk) disable iff (rst)
      timer_q[3:0] == MODE_PWM1 |-> !outputClass)
      else $error("mode 0010 gave output class");
   pwm2_clear_a : assert property (@(posedge clk) disable iff (rst)
      timer_q[3:0] == MODE_PWM2 && clear_q == CLR_BY_D |-> !outputClass)
      else $error("period pin produced output");
   trigger_copy_a : assert property (@(posedge clk) disable iff (rst)
      triggerLower |=> pulseData[3:0] == $past(nextData_q[3:0]))
      else $error("lower trigger did not copy");
   split_ones_a : assert property (@(posedge clk) disable iff (rst)
      regRead && !sameTrig && regAddr == OFS_NEXT_UPPER |=> regRdData[3:0] == 4'hF)
      else $error("reserved half not ones");
   pulse_pin_a : assert property (@(posedge clk) disable iff (rst)
      func == PF_PULSE_OUT |=> pinOut == $past(pulseData_q[3]))
      else $error("pulse bit not on pin");

   // pin driver roles
   port_output_a : assert property (@(posedge clk) disable iff (rst)
      func == PF_PORT_OUT |=> pinOe && pinOut == $past(control_q[CTL_PORT_DATA]))
      else $error("port data not on pin");

   pulse_drive_a : assert property (@(posedge clk) disable iff (rst)
      func == PF_PULSE_OUT |=> pinOe)
      else $error("pulse pin not driven");

   serial_func_a : assert property (@(posedge clk) disable iff (rst)
      control_q[CTL_TX_EN] |-> func == PF_SERIAL_OUT)
      else $error("serial enable lost priority");

   // capture and interrupt side paths
   capture_level_a : assert property (@(posedge clk) disable iff (rst)
      captureRoute |=> timerCaptureD == $past(pinSync2_q))
      else $error("capture level wrong");

   int_off_a : assert property (@(posedge clk) disable iff (rst)
      !control_q[CTL_INT_SEL] |=> !extInt11)
      else $error("interrupt fed while unselected");

   // class decode per timer mode
   normal_class_a : assert property (@(posedge clk) disable iff (rst)
      timer_q[3:0] == MODE_NORMAL |-> outputClass == (!timer_q[7] && timer_q[5:4] != 2'h0))
      else $error("compare class decode wrong");

   pwm2_class_a : assert property (@(posedge clk) disable iff (rst)
      timer_q[3:0] == MODE_PWM2 |-> outputClass == (timer_q[5:4] != 2'h0 && clear_q != CLR_BY_D))
      else $error("pwm mode 2 class wrong");

   // pwm pin mapping
   pwm1_pins_a : assert property (@(posedge clk) disable iff (rst)
      timer_q[3:0] == MODE_PWM1 |=> !pwmPinB && pwmPinA == $past(timerPwmA)
         && pwmPinC == $past(timerPwmC))
      else $error("pwm mode 1 pins wrong");

   pwm2_pins_a : assert property (@(posedge clk) disable iff (rst)
      timer_q[3:0] == MODE_PWM2 |=> pwmPinB == $past(timerPwmB))
      else $error("pwm mode 2 b pin wrong");

   // next data and pulse data
   upper_copy_a : assert property (@(posedge clk) disable iff (rst)
      !sameTrig && triggerUpper |=> pulseData[7:4] == $past(nextData_q[7:4]))
      else $error("upper trigger did not copy");

   pulse_hold_a : assert property (@(posedge clk) disable iff (rst)
      !triggerLower && !triggerUpper |=> $stable(pulseData))
      else $error("pulse data moved without trigger");

   shared_copy_a : assert property (@(posedge clk) disable iff (rst)
      sameTrig && triggerLower |=> pulseData == $past(nextData_q))
      else $error("shared trigger did not copy all");

   comb_write_a : assert property (@(posedge clk) disable iff (rst)
      regWrite && sameTrig && regAddr == OFS_NEXT_COMB |=> nextData_q == $past(regWrData))
      else $error("combined write lost");

   upper_write_a : assert property (@(posedge clk) disable iff (rst)
      regWrite && !sameTrig && regAddr == OFS_NEXT_UPPER
         |=> nextData_q[3:0] == $past(nextData_q[3:0]))
      else $error("upper write touched lower half");

   lower_ones_a : assert property (@(posedge clk) disable iff (rst)
      regRead && !sameTrig && regAddr == OFS_NEXT_LOWER |=> regRdData[7:4] == 4'hF)
      else $error("reserved upper half not ones");

   // read data only in the cycle after the strobe
   read_idle_a : assert property (@(posedge clk) disable iff (rst)
      !regRead |=> regRdData == 8'h00)
      else $error("read data outside its cycle");
endmodule // sppf_pin_select
`default_nettype wire

/* File: core/sppf_pkg.sv */
// constants for the shared port pin function select block
package sppf_pkg;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 8;
   // register offsets
   localparam logic [3:0]  OFS_NEXT_COMB   = 4'h0;
   localparam logic [3:0]  OFS_NEXT_UPPER  = 4'h1;
   localparam logic [3:0]  OFS_NEXT_LOWER  = 4'h2;
   localparam logic [3:0]  OFS_CONTROL     = 4'h3;
   localparam logic [3:0]  OFS_TIMER       = 4'h4;
   localparam logic [3:0]  OFS_STATUS      = 4'h5;
   localparam logic [3:0]  OFS_PULSE_DATA  = 4'h6;
   // control register fields
   localparam int          CTL_TX_EN       = 0;
   localparam int          CTL_DIR         = 1;
   localparam int          CTL_PO_EN       = 2;
   localparam int          CTL_INT_SEL     = 3;
   localparam int          CTL_SAME_TRIG   = 4;
   localparam int          CTL_PORT_DATA   = 5;
   // timer register fields: [3:0] mode, [7:4] d io control; clear held separately
   localparam int          TMR_MODE_LSB    = 0;
   localparam int          TMR_IOD_LSB     = 4;
   localparam int          CLR_LSB         = 0;
   // encodings
   localparam logic [3:0]  MODE_NORMAL     = 4'h0;
   localparam logic [3:0]  MODE_PWM1       = 4'h2;
   localparam logic [3:0]  MODE_PWM2       = 4'h3;
   localparam logic [2:0]  CLR_BY_D        = 3'h6;
   localparam logic [7:0]  RST_ZERO        = 8'h00;
   localparam logic [7:0]  RSV_ONES        = 8'hFF;
   localparam logic [7:0]  UNMAPPED_READ   = 8'h00;
   localparam int          PIN_BIT         = 3;
   typedef enum logic [2:0] {
      PF_PORT_IN, PF_PORT_OUT, PF_PULSE_OUT, PF_TIMER_OUT, PF_SERIAL_OUT
   } sppf_func_t;
endpackage : sppf_pkg

/* File: verification/sppf_pin_model.sv */
// external circuitry model on the shared pin
`timescale 1ns/100ps
`default_nettype none
module sppf_pin_model (
   input  wire logic pinOut,
   input  wire logic pinOe,
   input  wire logic extLevel,
   output var  logic pinIn
);
   // the device wins while it drives; otherwise the outside source sets the level
   always_comb pinIn = pinOe ? pinOut : extLevel;
endmodule // sppf_pin_model
`default_nettype wire

/* File: verification/sppf_pin_select_tb.sv */
// testbench for the shared port pin function select block
`timescale 1ns/100ps
`default_nettype none
module sppf_pin_select_tb;
   import sppf_pkg::*;
   logic clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [7:0] regWrData = 8'h00, regRdData, pulseData;
   logic trigU = 1'b0, trigL = 1'b0, txD = 1'b0, cmpD = 1'b0, pwmB = 1'b0, extLevel = 1'b1;
   logic pinIn, pinOut, pinOe, capD, int11, pA, pB, pC;
   int   miscompares = 0, samples_checked = 0;
   logic [3:0] iod;
   logic [2:0] clr;
   logic       expOe;
   always #2 clk = ~clk;
   sppf_pin_select dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .triggerUpper(trigU),
      .triggerLower(trigL), .serialTxData(txD), .timerCompareD(cmpD), .timerPwmA(pwmB),
      .timerPwmB(pwmB), .timerPwmC(pwmB), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .timerCaptureD(capD), .extInt11(int11), .pwmPinA(pA), .pwmPinB(pB), .pwmPinC(pC),
      .pulseData(pulseData));
   sppf_pin_model partner (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) begin
         regAddr <= a; regWrData <= d; regWrite <= 1'b1;
      end
      @(posedge clk) regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk) begin
         regAddr <= a; regRead <= 1'b1;
      end
      @(posedge clk) regRead <= 1'b0;
      #1 chk(regRdData, exp);
   endtask
   task automatic trig(input logic upper);
      @(posedge clk) if (upper) trigU <= 1'b1; else trigL <= 1'b1;
      @(posedge clk) begin
         trigU <= 1'b0; trigL <= 1'b0;
      end
      @(posedge clk) #1;
   endtask
   // control, timer and clear registers, then let pin outputs settle
   task automatic cfg(input logic [7:0] ctl, input logic [7:0] tmr, input logic [7:0] c);
      wr(OFS_CONTROL, ctl);
      wr(OFS_TIMER, tmr);
      wr(OFS_STATUS, c);
      repeat (5) @(posedge clk);
      #1;
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      stop_test();
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_NEXT_LOWER, 8'hF0);
      rd(OFS_NEXT_UPPER, 8'h0F);
      rd(OFS_NEXT_COMB, 8'h00);
      rd(4'h7, 8'h00);
      wr(OFS_NEXT_UPPER, 8'hA5);
      wr(OFS_NEXT_LOWER, 8'h3C);
      wr(OFS_NEXT_COMB, 8'hFF);
      rd(OFS_NEXT_UPPER, 8'hAF);
      rd(OFS_NEXT_LOWER, 8'hFC);
      trig(1'b0);
      chk(pulseData, 8'h0C);
      trig(1'b1);
      chk(pulseData, 8'hAC);
      rd(OFS_PULSE_DATA, 8'hAC);
      // shared trigger: one address holds all eight bits
      wr(OFS_CONTROL, 8'h10);
      rd(OFS_CONTROL, 8'h10);
      wr(OFS_NEXT_COMB, 8'h96);
      rd(OFS_NEXT_COMB, 8'h96);
      rd(OFS_NEXT_UPPER, 8'h00);
      trig(1'b0);
      chk(pulseData, 8'h96);
      rd(OFS_PULSE_DATA, 8'h96);
      // serial transmit overrides a timer output setting
      txD <= 1'b1;
      cfg(8'h13, 8'h10, 8'h00);
      chk({pinOe, pinOut}, 8'h03);
      rd(OFS_STATUS, 8'hC0);
      rd(OFS_TIMER, 8'h10);
      txD <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk({pinOe, pinOut}, 8'h02);
      // timer class decode over modes, d control values and clear settings
      cmpD <= 1'b1;
      pwmB <= 1'b1;
      for (int m = 0; m < 3; m++) begin
         for (int i = 0; i < 32; i++) begin
            iod = i[3:0];
            clr = i[4] ? CLR_BY_D : 3'h0;
            if (m == 0) expOe = !iod[3] && (iod[1:0] != 2'b00);
            else if (m == 1) expOe = 1'b0;
            else expOe = (iod[1:0] != 2'b00) && (clr != CLR_BY_D);
            cfg(8'h00, {iod, (m == 0) ? MODE_NORMAL : (m == 1) ? MODE_PWM1 : MODE_PWM2},
                {5'h00, clr});
            chk({pinOe, pinOut}, {6'h00, expOe, expOe});
            chk(capD, {7'h00, m == 0 && iod[3:2] == 2'b10});
            chk(pB, {7'h00, m != 1});
            chk({pA, pC}, 8'h03);
         end
      end
      // direction, port data and pulse enable pick the port roles
      cfg(8'h00, 8'h00, 8'h00);
      chk({pinOe, pinOut}, 8'h00);
      cfg(8'h22, 8'h00, 8'h00);
      chk({pinOe, pinOut}, 8'h03);
      cfg(8'h02, 8'h00, 8'h00);
      chk({pinOe, pinOut}, 8'h02);
      cfg(8'h36, 8'h00, 8'h00);
      chk({pinOe, pinOut}, 8'h02);
      wr(OFS_NEXT_COMB, 8'h08);
      trig(1'b0);
      repeat (2) @(posedge clk);
      #1 chk({pinOe, pinOut}, 8'h03);
      // interrupt select follows the pin level as an extra function
      cfg(8'h08, 8'h00, 8'h00);
      chk(int11, 8'h01);
      extLevel <= 1'b0;
      repeat (5) @(posedge clk);
      #1 chk(int11, 8'h00);
      extLevel <= 1'b1;
      cfg(8'h00, 8'h00, 8'h00);
      chk(int11, 8'h00);
      stop_test();
   end
endmodule // sppf_pin_select_tb
`default_nettype wire
